// ==== core/bsre_top.sv ====
`timescale 1ns/1ps
module bsre_top #(
  parameter int NPT = bsre_pkg::N_POINTS,
  parameter int IMM_CYCLES = bsre_pkg::IMM_CYC
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [1:0] phase_in,
  input wire logic irq_in,
  input wire logic instr_valid_in,
  input wire logic [3:0] op_in,
  input wire logic [1:0] area_in,
  input wire logic [bsre_pkg::IDX_W-1:0] idx_in,
  input wire logic [bsre_pkg::BIT_W-1:0] bit_in,
  input wire logic [bsre_pkg::WADDR_W-1:0] waddr_in,
  input wire logic [1:0] rel_in,
  input wire logic [bsre_pkg::WORD_W-1:0] cmp_a_in,
  input wire logic [bsre_pkg::WORD_W-1:0] cmp_b_in,
  input wire logic [bsre_pkg::WORD_W-1:0] word_data_in,
  input wire logic [NPT-1:0] system_flag_relay_in,
  input wire logic [NPT-1:0] in_pins_in,
  output logic ready_out,
  output logic done_out,
  output logic result_out,
  output logic [bsre_pkg::DEPTH_W-1:0] depth_out,
  output logic err_out,
  output logic ended_out,
  output logic [bsre_pkg::WADDR_W-1:0] word_addr_out,
  output logic [NPT-1:0] out_pins_out
);

  // ==========================================
  // declarations
  localparam logic [bsre_pkg::IMM_CNT_W-1:0] IMM_LAST =
    bsre_pkg::IMM_CNT_W'(IMM_CYCLES - 1);
  localparam logic [bsre_pkg::IMM_CNT_W-1:0] CNT_ONE =
    bsre_pkg::IMM_CNT_W'(1);

  bsre_pkg::bsre_state_e state;
  bsre_pkg::bsre_state_e next_state;
  bsre_pkg::bsre_op_e op_q;
  bsre_pkg::bsre_area_e area_q;
  bsre_pkg::bsre_rel_e rel_q;
  logic [bsre_pkg::IDX_W-1:0] idx_q;
  logic [bsre_pkg::POINT_W-1:0] pt;
  logic [bsre_pkg::BIT_W-1:0] bit_q;
  logic [bsre_pkg::WORD_W-1:0] cmp_a_q;
  logic [bsre_pkg::WORD_W-1:0] cmp_b_q;
  logic [bsre_pkg::IMM_CNT_W-1:0] imm_cnt;
  logic [NPT-1:0] pin_meta;
  logic [NPT-1:0] pin_sync;
  logic [NPT-1:0] in_img;
  logic [NPT-1:0] out_img;
  logic accept;
  logic is_imm;
  logic do_exec;
  logic act;
  logic coil_wr;
  logic relay_rd;
  logic src;
  logic wbit;
  logic cmp_res;
  logic imm_bit;
  logic stk_push;
  logic stk_val;
  logic stk_and;
  logic stk_or;
  logic stk_mand;
  logic stk_mor;
  logic stk_clr;
  logic stk_err;

  assign pt = idx_q[bsre_pkg::POINT_W-1:0];
  assign accept = instr_valid_in && ready_out &&
                  phase_in == bsre_pkg::PH_EXEC;
  assign is_imm = op_in == bsre_pkg::OP_IMM_OPEN ||
                  op_in == bsre_pkg::OP_IMM_CLOSED ||
                  op_in == bsre_pkg::OP_IMM_COIL;
  assign do_exec = state == bsre_pkg::ST_EXEC ||
                   (state == bsre_pkg::ST_IMM && imm_cnt == '0);
  assign act = do_exec && !(ended_out && !irq_in);
  assign coil_wr = act && (op_q == bsre_pkg::OP_COIL ||
                           op_q == bsre_pkg::OP_IMM_COIL);

  // ==========================================
  // pin synchroniser
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= in_pins_in;
      pin_sync <= pin_meta;
    end
  end

  // ==========================================
  // sequencing
  always_comb begin
    next_state = state;
    case (state)
      bsre_pkg::ST_IDLE: begin
        if (accept) begin
          next_state = is_imm ? bsre_pkg::ST_IMM : bsre_pkg::ST_FETCH;
        end
      end
      bsre_pkg::ST_FETCH: begin
        next_state = bsre_pkg::ST_EXEC;
      end
      bsre_pkg::ST_EXEC: begin
        next_state = bsre_pkg::ST_IDLE;
      end
      bsre_pkg::ST_IMM: begin
        if (imm_cnt == '0) begin
          next_state = bsre_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = bsre_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      state <= bsre_pkg::ST_IDLE;
      ready_out <= 1'b0;
      done_out <= 1'b0;
      imm_cnt <= '0;
    end else begin
      state <= next_state;
      ready_out <= next_state == bsre_pkg::ST_IDLE &&
                   phase_in == bsre_pkg::PH_EXEC;
      done_out <= do_exec;
      if (accept) begin
        imm_cnt <= IMM_LAST;
      end else if (state == bsre_pkg::ST_IMM && imm_cnt != '0) begin
        imm_cnt <= imm_cnt - CNT_ONE;
      end
    end
  end

  // ==========================================
  // instruction latch
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      op_q <= bsre_pkg::OP_PUSH_OPEN;
      area_q <= bsre_pkg::AREA_INPUT;
      rel_q <= bsre_pkg::REL_EQ;
      idx_q <= '0;
      bit_q <= '0;
      cmp_a_q <= '0;
      cmp_b_q <= '0;
      word_addr_out <= '0;
    end else if (accept) begin
      op_q <= bsre_pkg::bsre_op_e'(op_in);
      area_q <= bsre_pkg::bsre_area_e'(area_in);
      rel_q <= bsre_pkg::bsre_rel_e'(rel_in);
      idx_q <= idx_in;
      bit_q <= bit_in;
      cmp_a_q <= cmp_a_in;
      cmp_b_q <= cmp_b_in;
      word_addr_out <= waddr_in;
    end
  end

  // ==========================================
  // contact values and stack control
  always_comb begin
    case (area_q)
      bsre_pkg::AREA_INPUT: src = in_img[pt];
      bsre_pkg::AREA_OUTPUT: src = out_img[pt];
      bsre_pkg::AREA_RELAY: src = relay_rd;
      default: src = system_flag_relay_in[pt];
    endcase
    wbit = word_data_in[bit_q];
    case (rel_q)
      bsre_pkg::REL_EQ: cmp_res = cmp_a_q == cmp_b_q;
      bsre_pkg::REL_NE: cmp_res = cmp_a_q != cmp_b_q;
      bsre_pkg::REL_GE: cmp_res = cmp_a_q >= cmp_b_q;
      default: cmp_res = cmp_a_q < cmp_b_q;
    endcase
    imm_bit = pin_sync[pt];
    stk_push = 1'b0;
    stk_val = 1'b0;
    stk_and = 1'b0;
    stk_or = 1'b0;
    stk_mand = 1'b0;
    stk_mor = 1'b0;
    stk_clr = 1'b0;
    if (act) begin
      case (op_q)
        bsre_pkg::OP_PUSH_OPEN: begin
          stk_push = 1'b1;
          stk_val = src;
        end
        bsre_pkg::OP_PUSH_CLOSED: begin
          stk_push = 1'b1;
          stk_val = !src;
        end
        bsre_pkg::OP_PUSH_WB_OPEN: begin
          stk_push = 1'b1;
          stk_val = wbit;
        end
        bsre_pkg::OP_PUSH_WB_CLOSED: begin
          stk_push = 1'b1;
          stk_val = !wbit;
        end
        bsre_pkg::OP_AND_OPEN: begin
          stk_and = 1'b1;
          stk_val = src;
        end
        bsre_pkg::OP_AND_CLOSED: begin
          stk_and = 1'b1;
          stk_val = !src;
        end
        bsre_pkg::OP_OR_OPEN: begin
          stk_or = 1'b1;
          stk_val = src;
        end
        bsre_pkg::OP_OR_CLOSED: begin
          stk_or = 1'b1;
          stk_val = !src;
        end
        bsre_pkg::OP_MERGE_SERIES: stk_mand = 1'b1;
        bsre_pkg::OP_MERGE_PARALLEL: stk_mor = 1'b1;
        bsre_pkg::OP_CMP_PUSH: begin
          stk_push = 1'b1;
          stk_val = cmp_res;
        end
        bsre_pkg::OP_IMM_OPEN: begin
          stk_push = 1'b1;
          stk_val = imm_bit;
        end
        bsre_pkg::OP_IMM_CLOSED: begin
          stk_push = 1'b1;
          stk_val = !imm_bit;
        end
        bsre_pkg::OP_END: stk_clr = 1'b1;
        default: stk_clr = 1'b0;
      endcase
    end
  end

  bsre_stack u_stack (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .clr_in(stk_clr),
    .push_in(stk_push),
    .val_in(stk_val),
    .and_in(stk_and),
    .or_in(stk_or),
    .mrg_and_in(stk_mand),
    .mrg_or_in(stk_mor),
    .top_out(result_out),
    .depth_out(depth_out),
    .err_out(stk_err)
  );

  bsre_bitmem u_relays (
    .clk_in(clk_in),
    .wr_en_in(coil_wr && area_q == bsre_pkg::AREA_RELAY),
    .wr_addr_in(idx_q),
    .wr_data_in(result_out),
    .rd_addr_in(idx_q),
    .rd_data_out(relay_rd)
  );

  // ==========================================
  // image registers and pins
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      in_img <= '0;
    end else if (phase_in == bsre_pkg::PH_INPUT) begin
      in_img <= pin_sync;
    end else if (coil_wr && area_q == bsre_pkg::AREA_INPUT) begin
      in_img[pt] <= result_out;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      out_img <= '0;
    end else if (coil_wr && area_q == bsre_pkg::AREA_OUTPUT) begin
      out_img[pt] <= result_out;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      out_pins_out <= '0;
    end else if (phase_in == bsre_pkg::PH_OUTPUT) begin
      out_pins_out <= out_img;
    end else if (act && op_q == bsre_pkg::OP_IMM_COIL) begin
      out_pins_out[pt] <= result_out;
    end
  end

  // ==========================================
  // scan end and error flags
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      ended_out <= 1'b0;
      err_out <= 1'b0;
    end else begin
      if (phase_in == bsre_pkg::PH_INPUT) begin
        ended_out <= 1'b0;
        err_out <= 1'b0;
      end
      if (do_exec && op_q == bsre_pkg::OP_END) begin
        ended_out <= 1'b1;
      end
      if (stk_err) begin
        err_out <= 1'b1;
      end
    end
  end

  // ==========================================
  // checks
  busy_stall_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    state != bsre_pkg::ST_IDLE |-> !ready_out)
    else $error("ready while busy");
  imm_length_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    $rose(state == bsre_pkg::ST_IMM) |-> (state == bsre_pkg::ST_IMM)[*5]
    ##1 state == bsre_pkg::ST_IDLE)
    else $error("immediate stall has wrong length");
  imm_keep_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    state == bsre_pkg::ST_IMM && phase_in == bsre_pkg::PH_EXEC
    |=> $stable(in_img))
    else $error("immediate read changed the image");
  in_phase_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    phase_in == bsre_pkg::PH_INPUT |=> in_img == $past(pin_sync))
    else $error("input image not captured");
  out_phase_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    phase_in != bsre_pkg::PH_OUTPUT && state != bsre_pkg::ST_IMM
    |=> $stable(out_pins_out))
    else $error("pins moved outside output phase");
  imm_coil_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    act && op_q == bsre_pkg::OP_IMM_COIL &&
    phase_in != bsre_pkg::PH_OUTPUT && area_q == bsre_pkg::AREA_OUTPUT
    |=> out_pins_out[pt] == $past(result_out)
        && out_img[pt] == $past(result_out))
    else $error("immediate coil missed pin or image");
  coil_keep_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    act && op_q == bsre_pkg::OP_COIL |=> $stable(depth_out))
    else $error("coil popped the stack");
  end_skip_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    ended_out && !irq_in |-> !stk_push && !coil_wr)
    else $error("instruction ran after end");

  imm_read_c: cover property (@(posedge clk_in) disable iff (!nrst_in)
    act && op_q == bsre_pkg::OP_IMM_OPEN);
  overflow_c: cover property (@(posedge clk_in) disable iff (!nrst_in)
    stk_err);
  midline_c: cover property (@(posedge clk_in) disable iff (!nrst_in)
    act && op_q == bsre_pkg::OP_COIL ##[1:20] act && stk_and);

endmodule

// ==== core/bsre_pkg.sv ====
package bsre_pkg;

  // ==========================================
  // sizes
  localparam int STACK_DEPTH = 8;
  localparam int DEPTH_W = 4;
  localparam int N_POINTS = 256;
  localparam int POINT_W = 8;
  localparam int N_RELAYS = 512;
  localparam int IDX_W = 9;
  localparam int WORD_W = 16;
  localparam int BIT_W = 4;
  localparam int WADDR_W = 12;

  // ==========================================
  // timing
  localparam int CLK_NS = 40;
  localparam int IMM_ACCESS_NS = 200;
  localparam int IMM_CYC = (IMM_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int IMM_CNT_W = 4;

  // ==========================================
  // encodings
  typedef enum logic [3:0] {
    OP_PUSH_OPEN      = 4'h0,
    OP_PUSH_CLOSED    = 4'h1,
    OP_PUSH_WB_OPEN   = 4'h2,
    OP_PUSH_WB_CLOSED = 4'h3,
    OP_AND_OPEN       = 4'h4,
    OP_AND_CLOSED     = 4'h5,
    OP_OR_OPEN        = 4'h6,
    OP_OR_CLOSED      = 4'h7,
    OP_MERGE_SERIES   = 4'h8,
    OP_MERGE_PARALLEL = 4'h9,
    OP_COIL           = 4'ha,
    OP_CMP_PUSH       = 4'hb,
    OP_IMM_OPEN       = 4'hc,
    OP_IMM_CLOSED     = 4'hd,
    OP_IMM_COIL       = 4'he,
    OP_END            = 4'hf
  } bsre_op_e;

  typedef enum logic [1:0] {
    AREA_INPUT = 2'h0,
    AREA_OUTPUT = 2'h1,
    AREA_RELAY = 2'h2,
    AREA_FLAG = 2'h3
  } bsre_area_e;

  typedef enum logic [1:0] {
    PH_IDLE = 2'h0,
    PH_INPUT = 2'h1,
    PH_EXEC = 2'h2,
    PH_OUTPUT = 2'h3
  } bsre_phase_e;

  typedef enum logic [1:0] {
    REL_EQ = 2'h0,
    REL_NE = 2'h1,
    REL_GE = 2'h2,
    REL_LT = 2'h3
  } bsre_rel_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_FETCH = 2'h1,
    ST_EXEC = 2'h2,
    ST_IMM = 2'h3
  } bsre_state_e;

endpackage

// ==== core/bsre_bitmem.sv ====
`timescale 1ns/1ps
module bsre_bitmem #(
  parameter int DEPTH = bsre_pkg::N_RELAYS,
  parameter int AW = bsre_pkg::IDX_W
) (
  input wire logic clk_in,
  input wire logic wr_en_in,
  input wire logic [AW-1:0] wr_addr_in,
  input wire logic wr_data_in,
  input wire logic [AW-1:0] rd_addr_in,
  output logic rd_data_out
);

  // ==========================================
  // relay bit storage, registered read
  logic mem [DEPTH];

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_data_out <= mem[rd_addr_in];
  end

endmodule

// ==== core/bsre_stack.sv ====
`timescale 1ns/1ps
module bsre_stack #(
  parameter int DEPTH = bsre_pkg::STACK_DEPTH,
  parameter int DW = bsre_pkg::DEPTH_W
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic clr_in,
  input wire logic push_in,
  input wire logic val_in,
  input wire logic and_in,
  input wire logic or_in,
  input wire logic mrg_and_in,
  input wire logic mrg_or_in,
  output logic top_out,
  output logic [DW-1:0] depth_out,
  output logic err_out
);

  localparam logic [DW-1:0] FULL = DW'(DEPTH);
  localparam logic [DW-1:0] TWO = DW'(2);
  localparam logic [DW-1:0] ONE = DW'(1);

  logic [DEPTH-1:0] lvl;
  logic [DEPTH:0] ext;
  logic mrg_ok;
  logic mrg;

  assign ext = {1'b0, lvl};
  assign mrg_ok = depth_out >= TWO;
  assign mrg = (mrg_and_in || mrg_or_in) && mrg_ok;
  assign top_out = lvl[0];

  // ==========================================
  // stack levels
  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_lvl
      if (i == 0) begin : g_top
        always_ff @(posedge clk_in) begin
          if (!nrst_in || clr_in) begin
            lvl[0] <= 1'b0;
          end else if (push_in) begin
            lvl[0] <= val_in;
          end else if (and_in) begin
            lvl[0] <= lvl[0] & val_in;
          end else if (or_in) begin
            lvl[0] <= lvl[0] | val_in;
          end else if (mrg && mrg_and_in) begin
            lvl[0] <= lvl[0] & ext[1];
          end else if (mrg) begin
            lvl[0] <= lvl[0] | ext[1];
          end
        end
      end else begin : g_low
        always_ff @(posedge clk_in) begin
          if (!nrst_in || clr_in) begin
            lvl[i] <= 1'b0;
          end else if (push_in) begin
            lvl[i] <= lvl[i-1];
          end else if (mrg) begin
            lvl[i] <= ext[i+1];
          end
        end
      end
    end
  endgenerate

  // ==========================================
  // depth count and error
  always_ff @(posedge clk_in) begin
    if (!nrst_in || clr_in) begin
      depth_out <= '0;
      err_out <= 1'b0;
    end else begin
      err_out <= (push_in && depth_out == FULL) ||
                 ((mrg_and_in || mrg_or_in) && !mrg_ok);
      if (push_in && depth_out != FULL) begin
        depth_out <= depth_out + ONE;
      end else if (mrg) begin
        depth_out <= depth_out - ONE;
      end
    end
  end

  // ==========================================
  // checks
  push_top_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    push_in && !clr_in |=> top_out == $past(val_in))
    else $error("push did not land on top");
  shift_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    push_in && !clr_in |=> lvl[1] == $past(lvl[0]))
    else $error("push did not shift levels down");
  merge_and_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    mrg && mrg_and_in && !clr_in && !push_in && !and_in && !or_in
    |=> top_out == ($past(lvl[0]) & $past(lvl[1]))
        && depth_out == $past(depth_out) - ONE)
    else $error("series merge wrong");
  depth_max_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    depth_out <= FULL)
    else $error("stack deeper than its levels");
  overflow_a: assert property (@(posedge clk_in) disable iff (!nrst_in)
    push_in && !clr_in && depth_out == FULL |=> err_out)
    else $error("overflow not flagged");

endmodule

// ==== verif/bsre_wmem_model.sv ====
`timescale 1ns/1ps
// ==========================================
// word memory seen by the evaluator, one-cycle registered read
module bsre_wmem_model (
  input wire logic clk_in,
  input wire logic [bsre_pkg::WADDR_W-1:0] addr_in,
  output logic [bsre_pkg::WORD_W-1:0] data_out
);
  // contents are a fixed pattern of the address
  always_ff @(posedge clk_in) begin
    data_out <= 16'h1000 ^ {4'h0, addr_in};
  end
endmodule

// ==== verif/bsre_top_test.sv ====
`timescale 1ns/1ps
module bsre_top_test;
  // ==========================================
  // stimulus and observed signals
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic irq = 1'b0;
  logic valid = 1'b0;
  logic [1:0] phase = 2'h0;
  logic [1:0] area = 2'h0;
  logic [1:0] rel = 2'h0;
  logic [3:0] op = 4'h0;
  logic [3:0] bsel = 4'h0;
  logic [8:0] idx = 9'h0;
  logic [11:0] waddr = 12'h0;
  logic [15:0] cmp_a = 16'h0;
  logic [15:0] cmp_b = 16'h0;
  logic [255:0] flags = 256'h80;
  logic [255:0] pins = 256'h2;
  logic [15:0] wdata;
  logic ready, done, res, err, ended;
  logic [3:0] depth;
  logic [11:0] waddr_q;
  logic [255:0] opins;
  int failures = 0;
  int cmp_count = 0;

  always #20 clk_in = ~clk_in;

  bsre_top u_dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .phase_in(phase), .irq_in(irq),
    .instr_valid_in(valid), .op_in(op), .area_in(area), .idx_in(idx),
    .bit_in(bsel), .waddr_in(waddr), .rel_in(rel), .cmp_a_in(cmp_a),
    .cmp_b_in(cmp_b), .word_data_in(wdata), .system_flag_relay_in(flags),
    .in_pins_in(pins), .ready_out(ready), .done_out(done),
    .result_out(res), .depth_out(depth), .err_out(err),
    .ended_out(ended), .word_addr_out(waddr_q), .out_pins_out(opins)
  );

  bsre_wmem_model u_mem (
    .clk_in(clk_in), .addr_in(waddr_q), .data_out(wdata)
  );

  // ==========================================
  // compare and report
  task automatic chk_bit(input string what, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic chk_num(input string what, input logic [15:0] e,
                         input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ==========================================
  // instruction handshake
  task automatic issue(input logic [3:0] o, input logic [1:0] a,
                       input logic [8:0] i, output int lat);
    int n;
    @(posedge clk_in);
    op <= o;
    area <= a;
    idx <= i;
    valid <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (ready !== 1'b1 && n < 20);
    valid <= 1'b0;
    lat = 0;
    do begin
      @(posedge clk_in);
      lat++;
    end while (done !== 1'b1 && lat < 20);
  endtask

  task automatic step(input logic [3:0] o, input logic [1:0] a,
                      input logic [8:0] i, input logic er,
                      input logic [3:0] ed);
    int lat;
    issue(o, a, i, lat);
    chk_num("latency", (o >= 4'hc && o <= 4'he) ? 16'h6 : 16'h3,
            16'(lat));
    chk_bit("result", er, res);
    chk_num("depth", {12'h0, ed}, {12'h0, depth});
  endtask

  task automatic new_scan();
    phase <= 2'h1;
    repeat (5) @(posedge clk_in);
    phase <= 2'h2;
    repeat (2) @(posedge clk_in);
  endtask

  task automatic close_scan();
    int lat;
    issue(bsre_pkg::OP_END, 2'h0, 9'h0, lat);
    chk_bit("ended", 1'b1, ended);
    chk_num("depth after end", 16'h0, {12'h0, depth});
    new_scan();
  endtask

  // ==========================================
  // scenarios
  task automatic t_contacts();
    step(bsre_pkg::OP_PUSH_OPEN, 2'h0, 9'h1, 1'b1, 4'h1);
    step(bsre_pkg::OP_PUSH_CLOSED, 2'h0, 9'h1, 1'b0, 4'h2);
    step(bsre_pkg::OP_PUSH_OPEN, 2'h3, 9'h7, 1'b1, 4'h3);
    step(bsre_pkg::OP_AND_CLOSED, 2'h0, 9'h2, 1'b1, 4'h3);
    step(bsre_pkg::OP_AND_OPEN, 2'h0, 9'h2, 1'b0, 4'h3);
    step(bsre_pkg::OP_OR_OPEN, 2'h0, 9'h1, 1'b1, 4'h3);
    step(bsre_pkg::OP_AND_OPEN, 2'h0, 9'h2, 1'b0, 4'h3);
    step(bsre_pkg::OP_OR_CLOSED, 2'h0, 9'h2, 1'b1, 4'h3);
    close_scan();
    $display("test contacts done");
  endtask

  task automatic t_midline();
    step(bsre_pkg::OP_PUSH_OPEN, 2'h0, 9'h1, 1'b1, 4'h1);
    step(bsre_pkg::OP_COIL, 2'h1, 9'h2, 1'b1, 4'h1);
    step(bsre_pkg::OP_COIL, 2'h2, 9'h105, 1'b1, 4'h1);
    step(bsre_pkg::OP_AND_OPEN, 2'h0, 9'h2, 1'b0, 4'h1);
    step(bsre_pkg::OP_COIL, 2'h1, 9'h5, 1'b0, 4'h1);
    chk_bit("out pin 2 in exec", 1'b0, opins[2]);
    phase <= 2'h3;
    repeat (3) @(posedge clk_in);
    chk_bit("out pin 2", 1'b1, opins[2]);
    chk_bit("out pin 5", 1'b0, opins[5]);
    phase <= 2'h2;
    repeat (2) @(posedge clk_in);
    step(bsre_pkg::OP_PUSH_OPEN, 2'h2, 9'h105, 1'b1, 4'h2);
    close_scan();
    $display("test midline done");
  endtask

  task automatic t_wordbit();
    waddr <= 12'h300;
    bsel <= 4'hc;
    step(bsre_pkg::OP_PUSH_WB_OPEN, 2'h0, 9'h0, 1'b1, 4'h1);
    chk_num("word address", 16'h0300, {4'h0, waddr_q});
    bsel <= 4'hb;
    step(bsre_pkg::OP_PUSH_WB_OPEN, 2'h0, 9'h0, 1'b0, 4'h2);
    step(bsre_pkg::OP_PUSH_WB_CLOSED, 2'h0, 9'h0, 1'b1, 4'h3);
    bsel <= 4'hc;
    step(bsre_pkg::OP_PUSH_WB_CLOSED, 2'h0, 9'h0, 1'b0, 4'h4);
    close_scan();
    $display("test word bit done");
  endtask

  task automatic t_stack();
    step(bsre_pkg::OP_PUSH_OPEN, 2'h0, 9'h1, 1'b1, 4'h1);
    step(bsre_pkg::OP_PUSH_OPEN, 2'h0, 9'h2, 1'b0, 4'h2);
    step(bsre_pkg::OP_MERGE_PARALLEL, 2'h0, 9'h0, 1'b1, 4'h1);
    step(bsre_pkg::OP_PUSH_OPEN, 2'h0, 9'h2, 1'b0, 4'h2);
    step(bsre_pkg::OP_MERGE_SERIES, 2'h0, 9'h0, 1'b0, 4'h1);
    for (int k = 2; k <= 8; k++) begin
      step(bsre_pkg::OP_PUSH_OPEN, 2'h0, 9'h1, 1'b1, 4'(k));
    end
    chk_bit("error at eight", 1'b0, err);
    step(bsre_pkg::OP_PUSH_OPEN, 2'h0, 9'h2, 1'b0, 4'h8);
    @(posedge clk_in);
    chk_bit("error on ninth", 1'b1, err);
    close_scan();
    chk_bit("error after input phase", 1'b0, err);
    $display("test stack done");
  endtask

  task automatic t_compare();
    logic [15:0] b;
    logic e;
    cmp_a <= 16'h1234;
    for (int r = 0; r < 4; r++) begin
      for (int j = 0; j < 2; j++) begin
        b = 16'h1234 + 16'(j);
        e = (r == 0) ? (b == 16'h1234) : (r == 1) ? (b != 16'h1234) :
            (r == 2) ? (16'h1234 >= b) : (16'h1234 < b);
        rel <= 2'(r);
        cmp_b <= b;
        step(bsre_pkg::OP_CMP_PUSH, 2'h0, 9'h0, e, 4'(2 * r + j + 1));
      end
    end
    close_scan();
    $display("test compare done");
  endtask

  task automatic t_immediate();
    pins <= pins | 256'h8;
    repeat (3) @(posedge clk_in);
    step(bsre_pkg::OP_IMM_OPEN, 2'h0, 9'h3, 1'b1, 4'h1);
    step(bsre_pkg::OP_PUSH_OPEN, 2'h0, 9'h3, 1'b0, 4'h2);
    pins <= pins & ~256'h8;
    repeat (3) @(posedge clk_in);
    step(bsre_pkg::OP_IMM_CLOSED, 2'h0, 9'h3, 1'b1, 4'h3);
    step(bsre_pkg::OP_IMM_COIL, 2'h1, 9'h6, 1'b1, 4'h3);
    chk_bit("out pin 6 in exec", 1'b1, opins[6]);
    step(bsre_pkg::OP_PUSH_OPEN, 2'h1, 9'h6, 1'b1, 4'h4);
    close_scan();
    $display("test immediate done");
  endtask

  task automatic t_end();
    int lat;
    issue(bsre_pkg::OP_END, 2'h0, 9'h0, lat);
    chk_bit("ended", 1'b1, ended);
    step(bsre_pkg::OP_PUSH_OPEN, 2'h0, 9'h1, 1'b0, 4'h0);
    irq <= 1'b1;
    step(bsre_pkg::OP_PUSH_OPEN, 2'h0, 9'h1, 1'b1, 4'h1);
    close_scan();
    irq <= 1'b0;
    chk_bit("ended after input phase", 1'b0, ended);
    $display("test end done");
  endtask

  // ==========================================
  // main sequence and watchdog
  initial begin
    repeat (12) @(posedge clk_in);
    chk_bit("ready in reset", 1'b0, ready);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    new_scan();
    t_contacts();
    t_midline();
    t_wordbit();
    t_stack();
    t_compare();
    t_immediate();
    t_end();
    end_sim();
  end

  initial begin
    #200000;
    failures++;
    $display("ERROR watchdog expected finish seen timeout");
    end_sim();
  end
endmodule
